// file: rtl/tcs_defs.svh
// Bit positions, bus codes and limits for the tape controller status words.
// Assumes inclusion by bare name from the status word logic.
`ifndef TCS_DEFS_SVH
`define TCS_DEFS_SVH

`define TCS_SW1_POS_UNKNOWN 9
`define TCS_SW1_RESERVED 10
`define TCS_SW1_OP_CHECK 11
`define TCS_SW1_CORR_MEM 12
`define TCS_SW1_NONEXIST 13
`define TCS_SW1_BUS_PARITY 14
`define TCS_SW1_UNCORR_MEM 15

`define TCS_SW2_ONLINE 0
`define TCS_SW2_REWINDING 1
`define TCS_SW2_PROTECT 2
`define TCS_SW2_HIGH_DEN 3
`define TCS_SW2_RATE_ERR 4
`define TCS_SW2_TIMEOUT 10

`define TCS_FC_STATUS2 6'h1a
`define TCS_MIN_WRITE_RANGE 16'h0012
`define TCS_ZERO_RANGE 16'h0000

`endif

// file: rtl/tcs_pkg.sv
// Types shared by the tape controller status word logic.
// Assumes the constants header supplies every bit position and code.
package tcs_pkg;

   // Orders as presented to the status logic
   typedef enum logic [3:0] {
      TCS_ORD_NOP = 4'h0,
      TCS_ORD_READ = 4'h1,
      TCS_ORD_WRITE = 4'h2,
      TCS_ORD_WRITE_MARK = 4'h3,
      TCS_ORD_ERASE = 4'h4,
      TCS_ORD_REWIND = 4'h5,
      TCS_ORD_REWIND_UNLOAD = 4'h6,
      TCS_ORD_OTHER = 4'h7
   } tcs_order_e;

   // Response sequencer for the second status word request
   typedef enum logic [1:0] {
      TCS_RSP_IDLE = 2'b01,
      TCS_RSP_SEND = 2'b10
   } tcs_rsp_e;

endpackage

// file: rtl/tcs_status_words.sv
// Status word logic of a tape controller unit: the error bits of the
// primary status word, the drive bits of the secondary status word and
// the answer to the secondary status request.
// Assumes all bus and drive inputs are synchronous to clk and that each
// event strobe lasts one cycle.
`timescale 1ns/1ps
`include "tcs_defs.svh"

module tcs_status_words #(
   parameter int DUAL_DENSITY = 1
) (
   input wire logic clk, // System clock
   input wire logic reset_n, // Asynchronous reset, active low
   input wire logic initialize, // Initialize command pulse
   input wire logic task_word, // Output task word accepted, pulse
   input wire logic [3:0] order, // Order of that task word
   input wire logic transfer_task, // Task word is a data transfer
   input wire logic task_dir, // Direction of that transfer
   input wire logic chan_dir, // Direction bit from address command
   input wire logic standards_mode, // Standards configuration mode
   input wire logic [15:0] range, // Range register contents
   input wire logic command, // Any command to the channel, pulse
   input wire logic command_nop, // That command is no-operation
   input wire logic drive_ready, // Drive ready
   input wire logic online_switch, // Panel online switch on
   input wire logic panel_rewind, // Panel rewind switch pressed, pulse
   input wire logic rewind_done, // Rewind reached load point, pulse
   input wire logic ring_absent, // Write permit ring missing
   input wire logic density_select_switch, // High density selected
   input wire logic mem_corrected, // Corrected memory error, pulse
   input wire logic mem_uncorrected, // Uncorrected memory error, pulse
   input wire logic bus_nak, // NAK to own request, pulse
   input wire logic out_cycle, // Output bus cycle, pulse
   input wire logic [5:0] func_code, // Function code of that cycle
   input wire logic reply_cycle, // Second-half memory read, pulse
   input wire logic data_par_err, // Data byte parity error
   input wire logic addr_cmd, // Output address command, pulse
   input wire logic addr_par_err, // Address bits 0-7 parity error
   input wire logic [15:0] req_data, // Data bus bits 0-15 of request
   input wire logic [7:0] req_addr, // Address bus bits 0-7 of request
   input wire logic req_addr_par, // Parity of those address bits
   input wire logic status1_read, // Primary status read, pulse
   input wire logic status1_read_ok, // That read was free of error
   input wire logic position_lost, // Position unknown event, pulse
   input wire logic timeout_check, // Time-out check event, pulse
   input wire logic data_late, // Lost input or missing output, pulse
   output logic [15:0] primary_status_word, // Primary status word
   output logic [15:0] secondary_status_word, // Secondary status word
   output logic rsp_valid, // Reply cycle for secondary request
   output logic [23:0] rsp_addr, // Reply address bus bits 0-23
   output logic rsp_addr_par, // Reply parity of address bits 0-7
   output logic [15:0] rsp_data // Reply data, secondary status word
);

   // Elaboration check; a unit has either one density or two
   if (DUAL_DENSITY < 0 || DUAL_DENSITY > 1) begin : g_bad_density
      $error("DUAL_DENSITY must be 0 or 1");
   end


   // Sticky flags and drive state
   logic op_check;
   logic corr_mem;
   logic nonexist;
   logic bus_parity;
   logic uncorr_mem;
   logic pos_unknown;
   logic offline_latch;
   logic rewinding;
   logic rate_err;
   logic timeout_flag;
   tcs_pkg::tcs_rsp_e rsp_state;

   // Order decode
   wire logic ord_write_type;
   wire logic ord_write;
   wire logic ord_read;
   wire logic ord_rewind;
   wire logic ord_unload;
   assign ord_write = order == tcs_pkg::TCS_ORD_WRITE;
   assign ord_read = order == tcs_pkg::TCS_ORD_READ;
   assign ord_write_type = ord_write ||
      order == tcs_pkg::TCS_ORD_WRITE_MARK ||
      order == tcs_pkg::TCS_ORD_ERASE;
   assign ord_rewind = task_word && order == tcs_pkg::TCS_ORD_REWIND;
   assign ord_unload = task_word && order == tcs_pkg::TCS_ORD_REWIND_UNLOAD;

   // Online seen by the subsystem: switch on and not unloaded
   wire logic unit_online;
   assign unit_online = online_switch && !offline_latch;

   // Operation check causes
   wire logic oc_protect;
   wire logic oc_dir;
   wire logic oc_range;
   wire logic oc_offline;
   wire logic oc_set;
   assign oc_protect = task_word && ord_write_type && ring_absent;
   assign oc_dir = task_word && transfer_task && task_dir != chan_dir;
   assign oc_range = task_word && transfer_task && standards_mode && (
      ((ord_read || ord_write) && range == `TCS_ZERO_RANGE) ||
      (ord_write && range < `TCS_MIN_WRITE_RANGE));
   assign oc_offline = command && !command_nop &&
      (!unit_online || !drive_ready);
   assign oc_set = oc_protect || oc_dir || oc_range || oc_offline;

   // Parity causes; odd function code marks an output cycle
   wire logic par_set;
   assign par_set = (data_par_err && ((out_cycle && func_code[0]) ||
      reply_cycle)) || (addr_cmd && addr_par_err);

   // Clear terms; task word clears most error flags
   wire logic clr_task;
   wire logic clr_nonexist;
   wire logic clr_parity;
   assign clr_task = initialize || task_word;
   assign clr_nonexist = clr_task || status1_read;
   assign clr_parity = initialize || (status1_read && status1_read_ok);

   // Secondary request decode
   wire logic rsp_req;
   assign rsp_req = out_cycle && func_code == `TCS_FC_STATUS2;

   // Next flag values: set wins over clear so no event is lost
   wire logic next_op_check;
   wire logic next_corr_mem;
   wire logic next_nonexist;
   wire logic next_bus_parity;
   wire logic next_uncorr_mem;
   wire logic next_pos_unknown;
   wire logic next_rate_err;
   wire logic next_timeout;
   assign next_op_check = oc_set || (op_check && !clr_task);
   assign next_corr_mem = mem_corrected || (corr_mem && !clr_task);
   assign next_nonexist = bus_nak || (nonexist && !clr_nonexist);
   assign next_bus_parity = par_set || (bus_parity && !clr_parity);
   assign next_uncorr_mem = mem_uncorrected ||
      (uncorr_mem && !clr_task);
   assign next_timeout = timeout_check || (timeout_flag && !clr_task);
   assign next_pos_unknown = position_lost || timeout_check ||
      (pos_unknown && !clr_task);
   // Only a status bit; the transfer is never stopped from here
   assign next_rate_err = data_late || (rate_err && !clr_task);

   // Rewind in progress from command or panel until load point
   wire logic next_rewinding;
   assign next_rewinding = ord_rewind || ord_unload || panel_rewind ||
      (rewinding && !rewind_done && !initialize);

   // Unload latch released when the operator cycles the switch off
   wire logic next_offline;
   assign next_offline = ord_unload || (offline_latch && online_switch);

   // Status word assembly; unused positions stay zero
   logic [15:0] next_sw1;
   logic [15:0] next_sw2;
   wire logic high_den;
   assign high_den = (DUAL_DENSITY == 1) && density_select_switch;
   always_comb begin
      next_sw1 = 16'h0000;
      next_sw1[`TCS_SW1_POS_UNKNOWN] = next_pos_unknown;
      next_sw1[`TCS_SW1_OP_CHECK] = next_op_check;
      next_sw1[`TCS_SW1_CORR_MEM] = next_corr_mem;
      next_sw1[`TCS_SW1_NONEXIST] = next_nonexist;
      next_sw1[`TCS_SW1_BUS_PARITY] = next_bus_parity;
      next_sw1[`TCS_SW1_UNCORR_MEM] = next_uncorr_mem;
   end
   always_comb begin
      next_sw2 = 16'h0000;
      next_sw2[`TCS_SW2_ONLINE] = online_switch && !next_offline;
      next_sw2[`TCS_SW2_REWINDING] = next_rewinding;
      next_sw2[`TCS_SW2_PROTECT] = ring_absent;
      next_sw2[`TCS_SW2_HIGH_DEN] = high_den;
      next_sw2[`TCS_SW2_RATE_ERR] = next_rate_err;
      next_sw2[`TCS_SW2_TIMEOUT] = next_timeout;
   end

   // Operation check; cleared by initialize or a task word
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         op_check <= 1'b0;
      end else begin
         op_check <= next_op_check;
      end
   end

   // Corrected memory error; the data itself was usable
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         corr_mem <= 1'b0;
      end else begin
         corr_mem <= next_corr_mem;
      end
   end

   // Nonexistent resource; a primary status read clears it too
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         nonexist <= 1'b0;
      end else begin
         nonexist <= next_nonexist;
      end
   end

   // Bus parity; survives task words so the host still sees it
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         bus_parity <= 1'b0;
      end else begin
         bus_parity <= next_bus_parity;
      end
   end

   // Uncorrected memory error; the transfer keeps running
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         uncorr_mem <= 1'b0;
      end else begin
         uncorr_mem <= next_uncorr_mem;
      end
   end

   // Position unknown; also follows the time-out flag
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         pos_unknown <= 1'b0;
      end else begin
         pos_unknown <= next_pos_unknown;
      end
   end

   // Rate error; status only, the data path never waits on it
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rate_err <= 1'b0;
      end else begin
         rate_err <= next_rate_err;
      end
   end

   // Time-out check flag, shown in bit 10 of the secondary word
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         timeout_flag <= 1'b0;
      end else begin
         timeout_flag <= next_timeout;
      end
   end

   // Rewinding until load point or initialize
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rewinding <= 1'b0;
      end else begin
         rewinding <= next_rewinding;
      end
   end

   // Unload latch; the operator must cycle the switch to go online
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         offline_latch <= 1'b0;
      end else begin
         offline_latch <= next_offline;
      end
   end

   // Primary word, one cycle behind its causes
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         primary_status_word <= 16'h0000;
      end else begin
         primary_status_word <= next_sw1;
      end
   end

   // Secondary word; drive levels show up one cycle late
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         secondary_status_word <= 16'h0000;
      end else begin
         secondary_status_word <= next_sw2;
      end
   end

   // Reply sequencer: one reply cycle the edge after the request
   tcs_pkg::tcs_rsp_e next_rsp_state;
   always_comb begin
      next_rsp_state = rsp_state;
      unique case (rsp_state)
         tcs_pkg::TCS_RSP_IDLE: begin
            if (rsp_req) begin
               next_rsp_state = tcs_pkg::TCS_RSP_SEND;
            end
         end
         tcs_pkg::TCS_RSP_SEND: begin
            next_rsp_state = rsp_req ? tcs_pkg::TCS_RSP_SEND :
               tcs_pkg::TCS_RSP_IDLE;
         end
      endcase
   end

   // Echo fields captured with the request; held between replies
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rsp_state <= tcs_pkg::TCS_RSP_IDLE;
         rsp_valid <= 1'b0;
         rsp_addr <= 24'h000000;
         rsp_addr_par <= 1'b0;
         rsp_data <= 16'h0000;
      end else begin
         rsp_state <= next_rsp_state;
         rsp_valid <= next_rsp_state == tcs_pkg::TCS_RSP_SEND;
         if (rsp_req) begin
            rsp_addr <= {req_data, req_addr};
            rsp_addr_par <= req_addr_par;
            rsp_data <= next_sw2;
         end
      end
   end

endmodule

// file: test/tcs_bus_model.sv
// Host bus model issuing request cycles to the status logic.
// Assumes the bench holds go high one cycle per request.
`timescale 1ns/1ps
module tcs_bus_model (
   input wire logic clk, // Clock
   input wire logic go, // Issue request
   input wire logic [5:0] code, // Code
   input wire logic [15:0] data, // Data
   input wire logic [7:0] addr, // Address
   output logic out_cycle, // Strobe
   output logic [5:0] func_code, // Code
   output logic [15:0] req_data, // Data
   output logic [7:0] req_addr, // Address
   output logic req_addr_par // Parity
);
   logic [29:0] last = 30'h0;
   // Remember what was sent, so a released bus never repeats it
   always @(posedge clk) if (go) last <= {code, data, addr};
   // Released lines show the inverse of the last value
   assign out_cycle = go;
   assign {func_code, req_data, req_addr} = go ? {code, data, addr} : ~last;
   assign req_addr_par = ^req_addr;
endmodule

// file: test/tcs_status_asserts.sv
// Concurrent checks on the status word logic outputs.
// Assumes binding to tcs_status_words, one clock domain.
`timescale 1ns/1ps
module tcs_status_asserts (
   input wire logic clk, // Clock
   input wire logic reset_n, // Reset
   input wire logic initialize, // Init
   input wire logic mem_corrected, // Event
   input wire logic mem_uncorrected, // Event
   input wire logic bus_nak, // Event
   input wire logic out_cycle, // Request
   input wire logic [5:0] func_code, // Code
   input wire logic [15:0] req_data, // Data
   input wire logic [7:0] req_addr, // Address
   input wire logic req_addr_par, // Parity
   input wire logic status1_read, // Read
   input wire logic addr_cmd, // Event
   input wire logic addr_par_err, // Qualifier
   input wire logic data_late, // Event
   input wire logic [15:0] primary_status_word, // Word
   input wire logic [15:0] secondary_status_word, // Word
   input wire logic rsp_valid, // Reply
   input wire logic [23:0] rsp_addr, // Reply
   input wire logic rsp_addr_par // Reply
);
   // Short aliases keep the properties within the line width
   wire logic [15:0] p = primary_status_word;
   wire logic [15:0] s = secondary_status_word;
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   // Request for the secondary word
   sequence s_req;
      out_cycle && func_code == 6'h1a;
   endsequence
   chk_corr_sets: assert property (mem_corrected |=> p[12])
      else $error("corrected flag missing");
   chk_nak_sets: assert property (bus_nak |=> p[13])
      else $error("nonexistent flag missing");
   chk_uncorr_sets: assert property (mem_uncorrected |=> p[15])
      else $error("uncorrected flag missing");
   chk_reserved_zero: assert property (!p[10])
      else $error("reserved bit set");
   chk_reply_echo: assert property (s_req |=> rsp_valid &&
      rsp_addr == {$past(req_data), $past(req_addr)} &&
      rsp_addr_par == $past(req_addr_par))
      else $error("reply fields wrong");
   chk_reply_only: assert property (
      !(out_cycle && func_code == 6'h1a) |=> !rsp_valid)
      else $error("reply without request");
   chk_nonexist_clr: assert property (
      status1_read && !bus_nak |=> !p[13])
      else $error("nonexistent flag not cleared");
   // Only initialize or a status read may drop the parity flag
   chk_parity_hold: assert property (
      p[14] && !initialize && !status1_read |=> p[14])
      else $error("parity flag lost");
   chk_addr_par: assert property (addr_cmd && addr_par_err |=> p[14])
      else $error("address parity flag missing");
   chk_rate_sets: assert property (data_late |=> s[4])
      else $error("rate error flag missing");
endmodule

bind tcs_status_words tcs_status_asserts u_chk (.clk, .reset_n,
   .initialize, .mem_corrected, .mem_uncorrected, .bus_nak, .out_cycle,
   .func_code, .req_data, .req_addr, .req_addr_par, .status1_read,
   .addr_cmd, .addr_par_err, .data_late, .primary_status_word,
   .secondary_status_word, .rsp_valid, .rsp_addr, .rsp_addr_par);

// file: test/test_tape_controller_status_words.sv
// Bench for the tape controller status word logic.
// Assumes the host bus model and the checker are compiled first.
`timescale 1ns/1ps
module test_tape_controller_status_words;
   typedef struct {logic [7:0] ev; logic [15:0] pe, se;} tcs_row_s;
   logic clk, reset_n, initialize, task_word, transfer_task, task_dir;
   logic chan_dir, standards_mode, command, command_nop, drive_ready;
   logic online_switch, panel_rewind, rewind_done, ring_absent, den;
   logic mem_corrected, mem_uncorrected, bus_nak, reply_cycle, ok;
   logic data_par_err, addr_cmd, addr_par_err, status1_read, go;
   logic position_lost, timeout_check, data_late, out_cycle;
   logic req_addr_par, rsp_valid, rsp_addr_par;
   logic [3:0] order;
   logic [5:0] code, func_code;
   logic [7:0] addr, req_addr, ev;
   logic [15:0] range, data, req_data, p, s, rsp_data;
   logic [23:0] rsp_addr;
   int errors = 0;
   int checks = 0;
   // One event per row, words expected two edges later
   tcs_row_s rows [8] = '{
      '{8'h80, 16'h1000, 16'h0009}, '{8'h40, 16'h2000, 16'h0009},
      '{8'h20, 16'h8000, 16'h0009}, '{8'h10, 16'h0000, 16'h0019},
      '{8'h08, 16'h0200, 16'h0009}, '{8'h04, 16'h0200, 16'h0409},
      '{8'h02, 16'h4000, 16'h0009}, '{8'h01, 16'h4000, 16'h0009}};
   assign {mem_corrected, bus_nak, mem_uncorrected, data_late,
      position_lost, timeout_check, addr_cmd, reply_cycle} = ev;

   tcs_status_words #(.DUAL_DENSITY(1)) uut (.clk, .reset_n, .initialize,
      .task_word, .order, .transfer_task, .task_dir, .chan_dir,
      .standards_mode, .range, .command, .command_nop, .drive_ready,
      .online_switch, .panel_rewind, .rewind_done, .ring_absent,
      .density_select_switch(den), .mem_corrected, .mem_uncorrected,
      .bus_nak, .out_cycle, .func_code, .reply_cycle, .data_par_err,
      .addr_cmd, .addr_par_err, .req_data, .req_addr, .req_addr_par,
      .status1_read, .status1_read_ok(ok), .position_lost,
      .timeout_check, .data_late, .primary_status_word(p),
      .secondary_status_word(s), .rsp_valid, .rsp_addr, .rsp_addr_par,
      .rsp_data);
   tcs_bus_model host (.clk, .go, .code, .data, .addr, .out_cycle,
      .func_code, .req_data, .req_addr, .req_addr_par);

   task automatic cmp(input string n, input logic [23:0] e, g);
      checks++;
      if (g !== e) begin
         errors++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask
   // Strobes last exactly one cycle
   task automatic pulse(ref logic x);
      x = 1'b1;
      @(negedge clk);
      x = 1'b0;
      @(negedge clk);
   endtask
   task automatic opchk(input logic [3:0] o, input logic [2:0] xds,
         input logic [15:0] r, input logic e);
      order = o;
      {transfer_task, task_dir, standards_mode} = xds;
      range = r;
      pulse(task_word);
      cmp("op check", e, p[11]);
   endtask
   // Leaves go high so two requests can run back to back
   task automatic req(input logic [5:0] c, input logic [15:0] d,
         input logic [7:0] a);
      {code, data, addr, go} = {c, d, a, 1'b1};
      @(negedge clk);
   endtask
   task automatic rchk(input logic v, input logic [23:0] a, input logic pa);
      cmp("reply valid", v, rsp_valid);
      cmp("reply addr", a, rsp_addr);
      cmp("reply par", pa, rsp_addr_par);
      cmp("reply word", 16'h0009, rsp_data);
   endtask
   task automatic results;
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask

   // Clock at 125 MHz
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   // Watchdog, in case the sequence hangs
   initial begin
      #100000;
      errors++;
      results();
   end
   // Main sequence, all inputs move at the falling edge
   initial begin
      {initialize, task_word, transfer_task, task_dir, chan_dir, ok,
         standards_mode, command, command_nop, panel_rewind, rewind_done,
         ring_absent, status1_read, go, ev, order, code, addr, data} = '0;
      {online_switch, drive_ready, den, data_par_err, addr_par_err} = '1;
      range = 16'h0100;
      reset_n = 1'b0;
      repeat (2) @(negedge clk);
      cmp("word1 in reset", 16'h0000, p);
      reset_n = 1'b1;
      @(negedge clk);
      cmp("word2", 16'h0009, s);
      $display("reset test done");
      foreach (rows[i]) begin
         ev = rows[i].ev;
         @(negedge clk);
         ev = 8'h00;
         @(negedge clk);
         cmp("word1", rows[i].pe, p);
         cmp("word2", rows[i].se, s);
         pulse(initialize);
      end
      $display("table test done");
      ring_absent = 1'b1;
      for (int o = 2; o < 5; o++) opchk(o[3:0], 3'b000, 16'h0100, 1);
      opchk(4'h1, 3'b000, 16'h0100, 0);
      cmp("protect", 1, s[2]);
      ring_absent = 1'b0;
      opchk(4'h1, 3'b110, 16'h0100, 1);
      opchk(4'h1, 3'b100, 16'h0100, 0);
      opchk(4'h2, 3'b101, 16'h0011, 1);
      opchk(4'h2, 3'b101, 16'h0012, 0);
      opchk(4'h1, 3'b101, 16'h0000, 1);
      opchk(4'h0, 3'b000, 16'h0100, 0);
      drive_ready = 1'b0;
      command_nop = 1'b1;
      pulse(command);
      cmp("nop offline", 0, p[11]);
      command_nop = 1'b0;
      pulse(command);
      cmp("cmd offline", 1, p[11]);
      drive_ready = 1'b1;
      $display("op check test done");
      ev = 8'h42;
      @(negedge clk);
      ev = 8'h00;
      pulse(status1_read);
      cmp("read clears", 16'h4800, p);
      ev = 8'h40;
      @(negedge clk);
      ev = 8'h00;
      pulse(task_word);
      cmp("task clears", 16'h4000, p);
      ok = 1'b1;
      pulse(status1_read);
      cmp("clean read", 16'h0000, p);
      $display("clear test done");
      req(6'h1a, 16'ha5c3, 8'h80);
      rchk(1, 24'ha5c380, 1);
      req(6'h1a, 16'h0ff0, 8'h7e);
      rchk(1, 24'h0ff07e, 0);
      cmp("even code parity", 0, p[14]);
      req(6'h1b, 16'h1234, 8'h01);
      go = 1'b0;
      rchk(0, 24'h0ff07e, 0);
      cmp("odd code parity", 1, p[14]);
      $display("reply test done");
      order = 4'h5;
      pulse(task_word);
      cmp("rewinding", 1, s[1]);
      pulse(rewind_done);
      pulse(panel_rewind);
      cmp("panel rewind", 1, s[1]);
      pulse(rewind_done);
      order = 4'h6;
      pulse(task_word);
      cmp("unload", 16'h000a, s);
      pulse(rewind_done);
      online_switch = 1'b0;
      @(negedge clk);
      online_switch = 1'b1;
      @(negedge clk);
      cmp("online again", 16'h0009, s);
      den = 1'b0;
      @(negedge clk);
      cmp("low density", 16'h0001, s);
      $display("drive test done");
      results();
   end
endmodule
